// ### rtl/ecpc_ctrl.sv
/*
  External cache probe controller: probes the tag address and tag
  control RAMs, checks parity, finishes read hits (locked ones only with fast lock) and unlocked unshared write hits locally with shaped RAM
  strobes and hands everything else to system logic.
  Assumes the RAMs answer within the programmed read speed, and that the
  hold request is asynchronous while configuration is on this clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ecpc_ctrl
  import ecpc_pkg::*;
#(
  parameter int LATER_VARIANT = 1  // 1: 256 KB base size, fast lock present
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Static configuration
  input wire ecpc_cfg_t cfg_in,
  // Request from the memory unit
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_locked_in,
  input wire logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] req_addr_in,
  output logic req_ready_out,
  output logic done_out,
  output logic trap_out,
  // System logic side
  output logic external_req_out,
  input wire logic ext_done_in,
  input wire logic hold_in,
  // Tag RAMs
  input wire logic [ECPC_ADDR_HI:ECPC_TAG_LO] tag_address_lines_in,
  input wire logic tag_address_parity_in,
  input wire ecpc_tag_ctl_t tag_ctl_in,
  output ecpc_tag_ctl_t tag_ctl_out,
  output logic tag_ctl_oe_out,
  output logic tag_ram_strobe_out,
  output logic tag_control_write_strobe_out,
  // Data RAMs
  output logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] ram_address_out,
  output logic data_ram_low_address_out,
  output logic [3:0] data_ram_strobes_out,
  output logic [3:0] data_ram_write_strobes_out
);

  // Only the two known variants are served
  if (LATER_VARIANT != 0 && LATER_VARIANT != 1) begin : g_bad_variant
    $error("LATER_VARIANT must be 0 or 1");
  end

  ecpc_state_t st;  // Registered state
  ecpc_state_t nx;  // Next state

  logic [3:0] tag_shift;  // Low tag bits unused for this size
  logic [ECPC_TAG_W-1:0] tag_mask;  // Tag bits that take part
  logic tag_match;  // Masked address compare
  logic adr_perr;  // Tag address parity error
  logic ctl_perr;  // Tag control parity error
  logic perr;  // Either parity error
  logic hit;  // Valid, matching, clean parity
  logic local_read;  // Read finishes without system logic
  logic local_write;  // Write finishes without system logic
  logic probe_end;  // Last cycle of a tag probe
  logic taken;  // Request accepted this cycle
  logic [ECPC_CNT_W-1:0] wr_last;  // Last count of a write cycle

  // earlier base is 128 KB, later base is 256 KB
  always_comb begin
    tag_shift = {1'b0, st.cfg.cache_size_select} + 4'(LATER_VARIANT);
    if (tag_shift > ECPC_SHIFT_MAX) begin
      tag_shift = ECPC_SHIFT_MAX;
    end
    for (int i = 0; i < ECPC_TAG_W; i++) begin
      tag_mask[i] = (i >= int'(tag_shift));
    end
  end

  // Probe evaluation, valid only in the last probe cycle
  always_comb begin
    // masked compare, even parity over used bits
    tag_match = ((tag_address_lines_in ^ st.addr[ECPC_ADDR_HI:ECPC_TAG_LO]) & tag_mask) == '0;
    adr_perr = ^{tag_address_lines_in & tag_mask, tag_address_parity_in};
    // even parity over valid, shared, dirty
    ctl_perr = ^tag_ctl_in;
    perr = adr_perr | ctl_perr;
    // a low valid bit means invalid
    // a parity error forces a miss
    hit = tag_match & tag_ctl_in.valid & !perr;
    // reads need only valid; shared ignored
    // locked read local only with fast lock
    local_read = !st.write & hit & (!st.locked | (LATER_VARIANT == 1 & st.cfg.fast_lock_mode));
    // plain write hit to unshared block
    // shared write hit falls through to external
    local_write = st.write & !st.locked & hit & !tag_ctl_in.shared;
    probe_end = (st.state == ECPC_PROBE) & !st.hold & (st.cnt == st.cfg.read_speed_field);
    taken = req_valid_in & st.ready;
    wr_last = st.cfg.write_speed_field;
  end

  // Sequencer and registered outputs
  always_comb begin
    nx = st;
    // Hold pin: three stages, change once the last two agree
    nx.hold_sync = {st.hold_sync[ECPC_SYNC_STAGES-2:0], hold_in};
    if (st.hold_sync[2] == st.hold_sync[1]) begin
      nx.hold = st.hold_sync[2];
    end
    nx.done = 1'b0;
    nx.trap = 1'b0;
    case (st.state)
      // Wait for a request; none is taken during hold
      ECPC_IDLE: begin
        if (taken) begin
          nx.cfg = cfg_in;
          nx.addr = req_addr_in;
          nx.write = req_write_in;
          nx.locked = req_locked_in;
          nx.cnt = '0;
          nx.beat = 1'b0;
          // disabled or uncached quadrant skips the probe
          if (!cfg_in.cache_enable_bit ||
              cfg_in.uncached_quadrant_bits[req_addr_in[ECPC_ADDR_HI:ECPC_QUAD_LO]]) begin
            nx.state = ECPC_EXT;
          end else begin
            nx.state = ECPC_PROBE;
          end
        end
      end
      // Tag probe lasts read speed plus one cycles
      ECPC_PROBE: begin
        if (probe_end) begin
          nx.cnt = '0;
          // trap on parity error when enabled
          nx.trap = perr & st.cfg.machine_check_enable;
          if (local_read) begin
            // read hit served from data RAMs
            nx.state = ECPC_DATA_RD;
          end else if (local_write) begin
            nx.state = ECPC_DATA_WR;
          end else begin
            nx.state = ECPC_EXT;
          end
        end else if (!st.hold) begin
          nx.cnt = st.cnt + 1'b1;
        end
      end
      // two data beats make one 32-byte block
      // each read beat is read speed plus one cycles
      ECPC_DATA_RD: begin
        if (!st.hold) begin
          nx.cnt = st.cnt + 1'b1;
          if (st.cnt == st.cfg.read_speed_field) begin
            nx.cnt = '0;
            nx.beat = 1'b1;
            if (st.beat) begin
              nx.done = 1'b1;
              nx.state = ECPC_IDLE;
            end
          end
        end
      end
      // each write beat is write speed plus one cycles
      ECPC_DATA_WR: begin
        if (!st.hold) begin
          nx.cnt = st.cnt + 1'b1;
          if (st.cnt == wr_last) begin
            nx.cnt = '0;
            nx.beat = 1'b1;
            if (st.beat) begin
              nx.state = ECPC_TAG_WR;
            end
          end
        end
      end
      // block marked dirty after the data is written
      ECPC_TAG_WR: begin
        if (!st.hold) begin
          nx.cnt = st.cnt + 1'b1;
          if (st.cnt == wr_last) begin
            nx.done = 1'b1;
            nx.state = ECPC_IDLE;
          end
        end
      end
      // system logic owns the RAMs until it reports done
      ECPC_EXT: begin
        if (ext_done_in) begin
          nx.done = 1'b1;
          nx.state = ECPC_IDLE;
        end
      end
      default: begin
        nx.state = ECPC_IDLE;
      end
    endcase

    // Outputs follow the next state so they leave a flip-flop aligned with it
    nx.ready = (nx.state == ECPC_IDLE) & !nx.hold & !nx.done;
    nx.ext_req = (nx.state == ECPC_EXT);
    // tag strobe only in a probe, never during hold
    nx.tag_strobe = (nx.state == ECPC_PROBE) & !nx.hold &
                    (!nx.cfg.oe_timing_select | (nx.cnt != '0));
    // data strobes only in local data cycles
    nx.data_strobes = '0;
    if ((nx.state == ECPC_DATA_RD) && !nx.hold) begin
      // Output enable timing holds off the first cycle to avoid a bus clash
      nx.data_strobes = {4{!nx.cfg.oe_timing_select | (nx.cnt != '0)}};
    end else if ((nx.state == ECPC_DATA_WR) && !nx.hold) begin
      nx.data_strobes = {4{!nx.cfg.oe_timing_select}};
    end
    // write strobe placed by shape bits per cycle
    nx.data_we = '0;
    if ((nx.state == ECPC_DATA_WR) && !nx.hold && (nx.cnt < ECPC_CNT_W'(ECPC_SHAPE_W))) begin
      nx.data_we = {4{nx.cfg.write_strobe_shape_field[nx.cnt[1:0]]}};
    end
    // control write strobe uses the same shaping
    nx.tag_we = (nx.state == ECPC_TAG_WR) & !nx.hold &
                (nx.cnt < ECPC_CNT_W'(ECPC_SHAPE_W)) &
                nx.cfg.write_strobe_shape_field[nx.cnt[1:0]];
    nx.tag_oe = (nx.state == ECPC_TAG_WR) & !nx.hold;
    // valid, private, dirty with even parity
    nx.tag_wr.valid = 1'b1;
    nx.tag_wr.shared = 1'b0;
    nx.tag_wr.dirty = 1'b1;
    nx.tag_wr.parity = ^{nx.tag_wr.valid, nx.tag_wr.shared, nx.tag_wr.dirty};
    // low address bit is the beat, only in local data cycles
    nx.low_addr = ((nx.state == ECPC_DATA_RD) | (nx.state == ECPC_DATA_WR)) &
                  !nx.hold & nx.beat;
  end

  // State register; reset loads a constant only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= ECPC_STATE_RST;
    end else begin
      st <= nx;
    end
  end

  // Ports straight from the state register
  assign req_ready_out = st.ready;
  assign done_out = st.done;
  assign trap_out = st.trap;
  assign external_req_out = st.ext_req;
  assign tag_ctl_out = st.tag_wr;
  assign tag_ctl_oe_out = st.tag_oe;
  assign tag_ram_strobe_out = st.tag_strobe;
  assign tag_control_write_strobe_out = st.tag_we;
  // block address from the latched request
  assign ram_address_out = st.addr;
  assign data_ram_low_address_out = st.low_addr;
  assign data_ram_strobes_out = st.data_strobes;
  assign data_ram_write_strobes_out = st.data_we;

  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_write_data;
    st.state == ECPC_DATA_WR;
  endsequence

  sequence s_tag_update;
    st.state == ECPC_TAG_WR && tag_ctl_oe_out;
  endsequence

  property p_tag_strobe_gated;
    (st.state != ECPC_PROBE || st.hold) |-> !tag_ram_strobe_out;
  endproperty
  a_tag_strobe_gated: assert property (p_tag_strobe_gated)
    else $error("tag strobe active outside a probe");

  property p_ext_quiet;
    external_req_out |-> (data_ram_strobes_out == '0) && (data_ram_write_strobes_out == '0)
      && !data_ram_low_address_out && !tag_control_write_strobe_out;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("RAM strobes active during external cycle");

  property p_disabled_goes_ext;
    (taken && !cfg_in.cache_enable_bit) |=> external_req_out && !tag_ram_strobe_out;
  endproperty
  a_disabled_goes_ext: assert property (p_disabled_goes_ext)
    else $error("disabled cache did not go external");

  property p_ctl_parity;
    tag_ctl_oe_out |-> tag_ctl_out.parity == ^{tag_ctl_out.valid, tag_ctl_out.shared,
                                               tag_ctl_out.dirty};
  endproperty
  a_ctl_parity: assert property (p_ctl_parity)
    else $error("tag control parity not even");

  property p_dirty_after_write;
    s_write_data ##1 (st.state != ECPC_DATA_WR && !st.hold) |-> s_tag_update
      ##0 tag_ctl_out.dirty;
  endproperty
  a_dirty_after_write: assert property (p_dirty_after_write)
    else $error("write hit did not mark block dirty");

  property p_perr_miss;
    (probe_end && perr) |=> external_req_out && (trap_out == st.cfg.machine_check_enable);
  endproperty
  a_perr_miss: assert property (p_perr_miss)
    else $error("parity error did not force external miss");

  property p_read_hit_local;
    (probe_end && local_read) |=> (st.state == ECPC_DATA_RD) [*2];
  endproperty
  a_read_hit_local: assert property (p_read_hit_local)
    else $error("read hit did not complete locally");

  property p_shared_write_ext;
    (probe_end && st.write && hit && tag_ctl_in.shared) |=> external_req_out;
  endproperty
  a_shared_write_ext: assert property (p_shared_write_ext)
    else $error("shared write hit did not go external");

  property p_probe_length;
    $rose(st.state == ECPC_PROBE) && !st.hold && st.cfg.read_speed_field == 4'h1
      |-> (st.state == ECPC_PROBE) [*2] ##1 (st.state != ECPC_PROBE);
  endproperty
  a_probe_length: assert property (p_probe_length)
    else $error("probe length wrong");

endmodule

`default_nettype wire

// ### inc/ecpc_pkg.sv
/*
  Shared constants and carrier types for the external cache probe
  controller. Assumes a single 100 MHz clock and static configuration
  inputs driven by logic on that same clock.
*/
package ecpc_pkg;

  // Address layout
  localparam int ECPC_ADDR_HI = 33;  // Top physical address bit
  localparam int ECPC_TAG_LO = 17;   // Lowest tag bit, 128 KB minimum cache
  localparam int ECPC_BLOCK_LO = 5;  // One tag per 32-byte block
  localparam int ECPC_TAG_W = ECPC_ADDR_HI - ECPC_TAG_LO + 1;
  localparam int ECPC_QUAD_LO = 32;  // Quadrant select bits [33:32]

  // Size select limits
  localparam logic [3:0] ECPC_SHIFT_MAX = 4'h7;  // 16 MB from 128 KB
  localparam int ECPC_SHAPE_W = 4;   // Write strobe shape bits, one per cycle

  // Counter and synchroniser widths
  localparam int ECPC_CNT_W = 4;
  localparam int ECPC_SYNC_STAGES = 3;

  // Static configuration, sampled when a cycle starts
  typedef struct packed {
    logic [2:0] cache_size_select;
    logic cache_enable_bit;
    logic [3:0] uncached_quadrant_bits;
    logic [3:0] read_speed_field;
    logic [3:0] write_speed_field;
    logic [ECPC_SHAPE_W-1:0] write_strobe_shape_field;
    logic oe_timing_select;  // 1: output enable timing, 0: chip enable timing
    logic machine_check_enable;
    logic fast_lock_mode;
  } ecpc_cfg_t;

  // Tag control RAM word
  typedef struct packed {
    logic valid;
    logic shared;
    logic dirty;
    logic parity;
  } ecpc_tag_ctl_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ECPC_IDLE,
    ECPC_PROBE,
    ECPC_DATA_RD,
    ECPC_DATA_WR,
    ECPC_TAG_WR,
    ECPC_EXT
  } ecpc_state_e_t;

  // Whole controller state, outputs included
  typedef struct packed {
    ecpc_state_e_t state;
    logic [ECPC_SYNC_STAGES-1:0] hold_sync;
    logic hold;
    ecpc_cfg_t cfg;
    logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] addr;
    logic write;
    logic locked;
    logic [ECPC_CNT_W-1:0] cnt;
    logic beat;
    logic ready;
    logic done;
    logic ext_req;
    logic trap;
    logic tag_strobe;
    logic tag_we;
    ecpc_tag_ctl_t tag_wr;
    logic tag_oe;
    logic low_addr;
    logic [3:0] data_strobes;
    logic [3:0] data_we;
  } ecpc_state_t;

  // Reset value of the whole state
  localparam ecpc_state_t ECPC_STATE_RST = '0;

endpackage

// ### verification/ecpc_ram_model.sv
/*
  Behavioural model of the tag RAMs and of the system logic that
  shares them with the controller.
  Assumes the bench loads the stored tag word through hierarchy while
  the controller is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module ecpc_ram_model
  import ecpc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Controller side
  input wire logic tag_strobe_in,
  input wire logic tag_we_in,
  input wire logic tag_oe_in,
  input wire ecpc_tag_ctl_t tag_ctl_wire_in,
  input wire logic ext_req_in,
  input wire logic [31:0] ext_delay_in,
  // RAM read data and system answer
  output logic [ECPC_ADDR_HI:ECPC_TAG_LO] tag_addr_out,
  output logic tag_par_out,
  output ecpc_tag_ctl_t tag_ctl_out,
  output logic ext_done_out = 1'b0
);
  logic [ECPC_ADDR_HI:ECPC_TAG_LO] tag = '0;  // Stored tag address
  logic tag_par = 1'b0;  // Stored tag address parity
  ecpc_tag_ctl_t ctl = '0;  // Stored control word
  logic [ECPC_TAG_W+4:0] last = '0;  // Last word put on the lines
  int wait_cnt = 0;  // Cycles spent on an external cycle

  // data only while selected, a toggling pattern otherwise
  assign {tag_addr_out, tag_par_out, tag_ctl_out} = tag_strobe_in ? {tag, tag_par, ctl} : ~last;

  // Keeps the unselected pattern moving so a stale read alternates between the last word inverted and the last word
  always @(posedge clk_in) begin
    last <= tag_strobe_in ? {tag, tag_par, ctl} : ~last;
    // store the control word the controller writes
    if (tag_we_in && tag_oe_in) begin
      ctl <= tag_ctl_wire_in;
    end
    // system logic finishes an external cycle, promptly or slowly
    ext_done_out <= 1'b0;
    if (ext_req_in && !ext_done_out) begin
      if (wait_cnt >= ext_delay_in) begin
        ext_done_out <= 1'b1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/test_external_cache_probe_control.sv
/*
  Self-checking bench for the external cache probe controller: probes,
  hits, misses, parity errors, strobe lengths and hold.
  Assumes the RAM model answers tag reads and external cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_external_cache_probe_control
  import ecpc_pkg::*;
;
  localparam logic [ECPC_ADDR_HI:ECPC_TAG_LO] TAG0 = 17'h0a5c2;  // Reference tag
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  ecpc_cfg_t cfg_in;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic req_locked_in = 1'b0;
  logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] req_addr_in = '0;
  logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] addr_a;
  logic hold_in = 1'b0;
  logic ext_done_in, req_ready_out, done_out, trap_out, external_req_out, tag_ctl_oe_out;
  logic [ECPC_ADDR_HI:ECPC_TAG_LO] tag_address_lines_in;
  logic tag_address_parity_in, tag_ram_strobe_out, tag_control_write_strobe_out;
  ecpc_tag_ctl_t tag_ctl_in, tag_ctl_out, ram_ctl;
  logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] ram_address_out;
  logic data_ram_low_address_out;
  logic [3:0] data_ram_strobes_out, data_ram_write_strobes_out;
  logic seen_ext, seen_trap, seen_low, leak;  // Flags gathered per cycle
  int nstb, nwe, ntw, ntag;  // Strobe cycle counts per cycle
  int failures = 0;
  int check_count = 0;
  int ext_delay = 2;

  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;
  // Shared control lines: the controller wins while it drives
  assign tag_ctl_in = tag_ctl_oe_out ? tag_ctl_out : ram_ctl;

  ecpc_ctrl #(.LATER_VARIANT(1)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_locked_in(req_locked_in),
    .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .done_out(done_out),
    .trap_out(trap_out), .external_req_out(external_req_out), .ext_done_in(ext_done_in),
    .hold_in(hold_in), .tag_address_lines_in(tag_address_lines_in),
    .tag_address_parity_in(tag_address_parity_in), .tag_ctl_in(tag_ctl_in),
    .tag_ctl_out(tag_ctl_out), .tag_ctl_oe_out(tag_ctl_oe_out),
    .tag_ram_strobe_out(tag_ram_strobe_out),
    .tag_control_write_strobe_out(tag_control_write_strobe_out),
    .ram_address_out(ram_address_out), .data_ram_low_address_out(data_ram_low_address_out),
    .data_ram_strobes_out(data_ram_strobes_out),
    .data_ram_write_strobes_out(data_ram_write_strobes_out));

  ecpc_ram_model u_ram (.clk_in(clk_in), .tag_strobe_in(tag_ram_strobe_out),
    .tag_we_in(tag_control_write_strobe_out), .tag_oe_in(tag_ctl_oe_out),
    .tag_ctl_wire_in(tag_ctl_in), .ext_req_in(external_req_out), .ext_delay_in(ext_delay),
    .tag_addr_out(tag_address_lines_in), .tag_par_out(tag_address_parity_in),
    .tag_ctl_out(ram_ctl), .ext_done_out(ext_done_in));

  // Single comparison point
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Loads the tag word; parity covers only the tag bits in use
  task load(input logic [ECPC_ADDR_HI:ECPC_TAG_LO] t, input logic [2:0] vsd,
            input logic bad_a, input logic bad_c);
    @(negedge clk_in);
    u_ram.tag = t;
    u_ram.tag_par = (^(t >> (cfg_in.cache_size_select + 1))) ^ bad_a;
    u_ram.ctl = {vsd, (^vsd) ^ bad_c};
  endtask

  // One request: hold it until taken, then watch to completion
  task run(input logic wr, input logic lk, input logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] a);
    int n;
    {seen_ext, seen_trap, seen_low, leak} = '0;
    {nstb, nwe, ntw, ntag} = '0;
    n = 0;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_locked_in <= lk;
    req_addr_in <= a;
    do begin
      @(negedge clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 100);
    // A controller that never becomes ready ends the run as a failure
    if (req_ready_out !== 1'b1) begin
      failures++;
      close_out();
    end
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk_in);
      seen_ext |= external_req_out;
      seen_trap |= trap_out;
      seen_low |= data_ram_low_address_out;
      leak |= external_req_out & (tag_ram_strobe_out | (|data_ram_strobes_out)
        | (|data_ram_write_strobes_out) | tag_control_write_strobe_out | data_ram_low_address_out);
      nstb += int'(|data_ram_strobes_out);
      nwe += int'(|data_ram_write_strobes_out);
      ntw += int'(tag_control_write_strobe_out);
      ntag += int'(tag_ram_strobe_out);
      if (done_out === 1'b1) break;
    end
    if (n == 400) begin
      failures++;
      close_out();
    end
  endtask

  task probe(input logic wr, input logic lk, input logic [ECPC_ADDR_HI:ECPC_BLOCK_LO] a,
             input logic ext, input logic trap);
    run(wr, lk, a);
    check("external", seen_ext, ext);
    check("trap", seen_trap, trap);
    check("strobe during external", leak, 1'b0);
  endtask

  // Main sequence
  initial begin
    cfg_in = '0;
    cfg_in.cache_enable_bit = 1'b1;
    cfg_in.read_speed_field = 4'h1;
    cfg_in.write_speed_field = 4'h1;
    cfg_in.write_strobe_shape_field = 4'h3;
    cfg_in.machine_check_enable = 1'b1;
    cfg_in.fast_lock_mode = 1'b1;
    addr_a = {TAG0, 12'h123};
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check("outputs in reset", {tag_ram_strobe_out, tag_control_write_strobe_out,
      data_ram_low_address_out, data_ram_strobes_out, data_ram_write_strobes_out}, 0);
    @(posedge clk_in) reset_in <= 1'b0;
    load(TAG0, 3'b100, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b0, 1'b0);
    check("second beat", seen_low, 1'b1);
    check("block address", ram_address_out, addr_a);
    check("read strobe cycles", nstb, 4);
    check("tag strobe cycles", ntag, 2);
    // Write strobes follow the shape bits of each cycle
    // Highest bit first, so the last pass leaves the dirty word in the RAM
    for (int i = ECPC_SHAPE_W - 1; i >= 0; i--) begin
      @(posedge clk_in) cfg_in.write_strobe_shape_field <= 4'h1 << i;
      load(TAG0, 3'b100, 1'b0, 1'b0);
      probe(1'b1, 1'b0, addr_a, 1'b0, 1'b0);
      check("data write cycles", nwe, i < 2 ? 2 : 0);
      check("tag write cycles", ntw, i < 2 ? 1 : 0);
    end
    check("dirty word", u_ram.ctl, {3'b101, 1'b0});
    load(TAG0, 3'b110, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b0, 1'b0);
    probe(1'b1, 1'b0, addr_a, 1'b1, 1'b0);
    load(TAG0, 3'b011, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    load(TAG0 ^ 17'h00100, 3'b100, 1'b0, 1'b0);
    ext_delay = 20;
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    ext_delay = 2;
    load(TAG0, 3'b100, 1'b1, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b1);
    load(TAG0, 3'b100, 1'b0, 1'b1);
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b1);
    probe(1'b1, 1'b1, addr_a, 1'b1, 1'b1);
    @(posedge clk_in) cfg_in.machine_check_enable <= 1'b0;
    load(TAG0, 3'b100, 1'b1, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    load(TAG0, 3'b100, 1'b0, 1'b0);
    probe(1'b0, 1'b1, addr_a, 1'b0, 1'b0);
    probe(1'b1, 1'b1, addr_a, 1'b1, 1'b0);
    @(posedge clk_in) cfg_in.fast_lock_mode <= 1'b0;
    probe(1'b0, 1'b1, addr_a, 1'b1, 1'b0);
    @(posedge clk_in) cfg_in.cache_enable_bit <= 1'b0;
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    @(posedge clk_in) cfg_in.cache_enable_bit <= 1'b1;
    cfg_in.uncached_quadrant_bits <= 4'h1 << addr_a[ECPC_QUAD_LO+1:ECPC_QUAD_LO];
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    @(posedge clk_in) cfg_in.uncached_quadrant_bits <= ~cfg_in.uncached_quadrant_bits;
    // Slower reads with output enable timing drop the first cycle of each beat
    cfg_in.read_speed_field <= 4'h3;
    cfg_in.oe_timing_select <= 1'b1;
    probe(1'b0, 1'b0, addr_a, 1'b0, 1'b0);
    check("oe strobe cycles", nstb, 6);
    check("oe tag strobe cycles", ntag, 3);
    // Size select 3 keeps tag bits from 21 upward in the compare
    @(posedge clk_in) cfg_in.cache_size_select <= 3'h3;
    load(TAG0 ^ 17'h00008, 3'b100, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b0, 1'b0);
    load(TAG0 ^ 17'h00010, 3'b100, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b1, 1'b0);
    // Hold takes the RAMs away from the controller
    @(posedge clk_in) hold_in <= 1'b1;
    repeat (8) @(negedge clk_in);
    check("ready in hold", req_ready_out, 1'b0);
    check("strobes in hold", {tag_ram_strobe_out, data_ram_strobes_out}, 0);
    @(posedge clk_in) hold_in <= 1'b0;
    load(TAG0, 3'b100, 1'b0, 1'b0);
    probe(1'b0, 1'b0, addr_a, 1'b0, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
